// file: core/bscrc_unit.sv
// crc unit: byte-serial 16-bit checksum with register file on the byte bus
//
// Overview of operation
// - each input byte write updates the checksum once
// - update completes in one cycle, readable next
// - xor input byte into checksum upper byte
// - eight steps, each shifts left inserting zero
// - xor polynomial when leaving msb is one
// - 8005h for crc-16, 1021h for ccitt
// - eight steps, result written back to pair
// - checksum holds between writes, accumulating bytes
// - software clears both checksum bytes first
// - software selects polynomial before data bytes
// - program words go low byte then high
// - final pair value is the result
// - control bit0 selects polynomial, resets zero
// - input and checksum bytes reset to zero
//
// usage notes
// clear both checksum bytes and pick the polynomial before the first byte
// write bytes in order; each one is folded in before the next cycle
// a read returns the pair as it stood at the read strobe
// a read in the same cycle as a write returns the value from before it
// the input register keeps the last byte for read-back only
`timescale 1ns/1ps
module bscrc_unit
    import bscrc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // byte bus from the host
    bscrc_if.dev bus,
    // observed state
    output logic [15:0] running_checksum,
    output logic polynomial_select,
    output logic update_done
);
    // input byte register and its next value
    logic [7:0] crc_input_byte_q;
    logic [7:0] crc_input_byte_d;
    // running checksum pair, high byte in 15:8
    logic [15:0] sum_q;
    logic [15:0] sum_d;
    // polynomial select bit
    logic polynomial_select_q;
    logic polynomial_select_d;
    // update pulse
    logic done_q;
    logic done_d;
    // registered read data
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    // checksum chain, stage 0 is the seeded value
    logic [15:0] step_val [0:BSCRC_STEPS];
    logic [15:0] polynomial_select_const;
    logic [15:0] seed_val;
    logic [15:0] next_sum;
    // bus decode
    logic wr_input;
    logic wr_low;
    logic wr_high;
    logic wr_ctrl;
    logic rd_any;
    // control register as seen on a read, upper bits zero
    logic [7:0] ctrl_view;

    // write decode: one strobe per register, qualified by wr_en
    assign wr_input = bus.wr_en && (bus.addr == BSCRC_IDX_INPUT);
    assign wr_low = bus.wr_en && (bus.addr == BSCRC_IDX_LOW);
    assign wr_high = bus.wr_en && (bus.addr == BSCRC_IDX_HIGH);
    assign wr_ctrl = bus.wr_en && (bus.addr == BSCRC_IDX_CTRL);
    // reads need no decode beyond the strobe, the address picks the byte
    assign rd_any = bus.rd_en;

    // polynomial constant chosen by the select bit
    // the select resets to ccitt, so an unprogrammed unit still gives a valid sum
    assign polynomial_select_const = polynomial_select_q ? BSCRC_POLYNOMIAL_SELECT_CRC16 : BSCRC_POLYNOMIAL_SELECT_CCITT;

    // new byte folds into the upper half only; the lower half passes through
    assign seed_val = sum_q ^ {bus.wdata, BSCRC_BYTE_RST};
    assign step_val[0] = seed_val;

    // unrolled shift/xor chain, one stage per input bit
    // all stages settle within one clock, so the pair is readable next cycle
    // the critical path is eight xor stages in series
    genvar g;
    generate
        for (g = 0; g < BSCRC_STEPS; g++) begin : g_step
            // shift left with a zero into the lsb, then fold in the polynomial
            // only when the bit pushed out of the msb was one
            assign step_val[g+1] = step_val[g][15]
                ? ({step_val[g][14:0], 1'b0} ^ polynomial_select_const)
                : {step_val[g][14:0], 1'b0};
        end
    endgenerate

    // output of the last stage is the new checksum
    assign next_sum = step_val[BSCRC_STEPS];

    // control view: only the select bit is implemented
    assign ctrl_view = {7'h00, polynomial_select_q};

    // input byte and update pulse
    always_comb begin
        crc_input_byte_d = crc_input_byte_q;
        done_d = 1'b0;
        if (wr_input) begin
            crc_input_byte_d = bus.wdata;
            done_d = 1'b1;
        end
    end

    // checksum pair: stepped on an input write, loaded on a direct write
    // an input write never meets a direct load: one address per cycle
    always_comb begin
        sum_d = sum_q;
        if (wr_input) begin
            sum_d = next_sum;
        end
        if (wr_low) begin
            // direct load lets software clear or preset the pair
            sum_d[7:0] = bus.wdata;
        end
        if (wr_high) begin
            sum_d[15:8] = bus.wdata;
        end
    end

    // polynomial select, bit 0 of the control byte
    always_comb begin
        polynomial_select_d = polynomial_select_q;
        if (wr_ctrl) begin
            polynomial_select_d = bus.wdata[BSCRC_POLYNOMIAL_SELECT_BIT];
        end
    end

    // read data is registered, so it stands one cycle after rd_en
    // and holds until the next read
    always_comb begin
        rdata_d = rdata_q;
        if (rd_any) begin
            case (bus.addr)
                BSCRC_IDX_INPUT: begin
                    rdata_d = crc_input_byte_q;
                end
                BSCRC_IDX_LOW: begin
                    rdata_d = sum_q[7:0];
                end
                BSCRC_IDX_HIGH: begin
                    rdata_d = sum_q[15:8];
                end
                BSCRC_IDX_CTRL: begin
                    rdata_d = ctrl_view;
                end
                // only an unknown index lands here
                default: begin
                    rdata_d = BSCRC_BYTE_RST;
                end
            endcase
        end
    end

    // input byte and update pulse registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            crc_input_byte_q <= BSCRC_BYTE_RST;
            done_q <= 1'b0;
        end else begin
            crc_input_byte_q <= crc_input_byte_d;
            done_q <= done_d;
        end
    end

    // checksum pair register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sum_q <= BSCRC_SUM_RST;
        end else begin
            sum_q <= sum_d;
        end
    end

    // polynomial select register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            polynomial_select_q <= BSCRC_POLYNOMIAL_SELECT_RST;
        end else begin
            polynomial_select_q <= polynomial_select_d;
        end
    end

    // read data register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= BSCRC_BYTE_RST;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // outputs straight from the registers
    // the update pulse lasts exactly one cycle per input write
    assign bus.rdata = rdata_q;
    assign running_checksum = sum_q;
    assign polynomial_select = polynomial_select_q;
    assign update_done = done_q;
endmodule

// file: inc/bscrc_pkg.sv
// package: register indices, field positions and constants of the byte crc unit
package bscrc_pkg;
    localparam int BSCRC_AW = 2;
    localparam int BSCRC_DW = 8;
    // register indices on the internal byte bus
    localparam logic [1:0] BSCRC_IDX_INPUT = 2'h0;
    localparam logic [1:0] BSCRC_IDX_LOW = 2'h1;
    localparam logic [1:0] BSCRC_IDX_HIGH = 2'h2;
    localparam logic [1:0] BSCRC_IDX_CTRL = 2'h3;
    // control field and reset values
    localparam int BSCRC_POLYNOMIAL_SELECT_BIT = 0;
    localparam logic [7:0] BSCRC_BYTE_RST = 8'h00;
    localparam logic [15:0] BSCRC_SUM_RST = 16'h0000;
    localparam logic BSCRC_POLYNOMIAL_SELECT_RST = 1'b0;
    // polynomial constants: select 0 is ccitt, 1 is crc-16
    localparam logic [15:0] BSCRC_POLYNOMIAL_SELECT_CCITT = 16'h1021;
    localparam logic [15:0] BSCRC_POLYNOMIAL_SELECT_CRC16 = 16'h8005;
    localparam int BSCRC_STEPS = 8;
    // host sequencer command codes
    typedef enum logic [1:0] {
        BSCRC_CMD_CLEAR,
        BSCRC_CMD_POLYNOMIAL_SELECT,
        BSCRC_CMD_WORD,
        BSCRC_CMD_BYTE
    } bscrc_cmd_t;
endpackage

// file: inc/bscrc_if.sv
// interface: byte bus between the processor-side host and the crc unit
`timescale 1ns/1ps
interface bscrc_if;
    import bscrc_pkg::*;
    logic wr_en;
    logic rd_en;
    logic [BSCRC_AW-1:0] addr;
    logic [BSCRC_DW-1:0] wdata;
    logic [BSCRC_DW-1:0] rdata;
    modport dev (input wr_en, input rd_en, input addr, input wdata, output rdata);
    modport host (output wr_en, output rd_en, output addr, output wdata, input rdata);
endinterface

// file: core/bscrc_host.sv
// host end: turns user commands into the documented software sequence
`timescale 1ns/1ps
module bscrc_host
    import bscrc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // user command port
    input wire logic cmd_valid,
    input wire bscrc_cmd_t cmd,
    input wire logic [15:0] cmd_data,
    output logic cmd_ready,
    // result
    output logic [15:0] result,
    output logic result_valid,
    // byte bus to the crc unit
    bscrc_if.host bus
);
    typedef enum logic [2:0] {
        S_IDLE, S_CLR_HI, S_WR_HI, S_RD_LO, S_RD_HI, S_DONE
    } bscrc_hstate_t;
    bscrc_hstate_t st_q, st_d;
    logic [7:0] hi_q, hi_d;
    logic [15:0] res_q, res_d;
    logic rv_q, rv_d;

    // sequencer: clear, select, bytes, then read back the pair
    always_comb begin
        st_d = st_q;
        hi_d = hi_q;
        res_d = res_q;
        rv_d = 1'b0;
        bus.wr_en = 1'b0;
        bus.rd_en = 1'b0;
        bus.addr = BSCRC_IDX_INPUT;
        bus.wdata = BSCRC_BYTE_RST;
        cmd_ready = 1'b0;
        case (st_q)
            S_IDLE: begin
                cmd_ready = 1'b1;
                if (cmd_valid) begin
                    bus.wr_en = 1'b1;
                    case (cmd)
                        BSCRC_CMD_CLEAR: begin
                            bus.addr = BSCRC_IDX_LOW;
                            st_d = S_CLR_HI;
                        end
                        BSCRC_CMD_POLYNOMIAL_SELECT: begin
                            bus.addr = BSCRC_IDX_CTRL;
                            bus.wdata = {7'h00, cmd_data[BSCRC_POLYNOMIAL_SELECT_BIT]};
                        end
                        BSCRC_CMD_WORD: begin
                            bus.wdata = cmd_data[7:0];
                            hi_d = cmd_data[15:8];
                            st_d = S_WR_HI;
                        end
                        default: begin
                            bus.wdata = cmd_data[7:0];
                            st_d = S_RD_LO;
                        end
                    endcase
                end
            end
            S_CLR_HI: begin
                bus.wr_en = 1'b1;
                bus.addr = BSCRC_IDX_HIGH;
                st_d = S_RD_LO;
            end
            S_WR_HI: begin
                bus.wr_en = 1'b1;
                bus.wdata = hi_q;
                st_d = S_RD_LO;
            end
            S_RD_LO: begin
                bus.rd_en = 1'b1;
                bus.addr = BSCRC_IDX_LOW;
                st_d = S_RD_HI;
            end
            S_RD_HI: begin
                bus.rd_en = 1'b1;
                bus.addr = BSCRC_IDX_HIGH;
                res_d[7:0] = bus.rdata;
                st_d = S_DONE;
            end
            S_DONE: begin
                res_d[15:8] = bus.rdata;
                rv_d = 1'b1;
                st_d = S_IDLE;
            end
            default: st_d = S_IDLE;
        endcase
    end

    // state registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= S_IDLE;
            hi_q <= BSCRC_BYTE_RST;
            res_q <= BSCRC_SUM_RST;
            rv_q <= 1'b0;
        end else begin
            st_q <= st_d;
            hi_q <= hi_d;
            res_q <= res_d;
            rv_q <= rv_d;
        end
    end

    assign result = res_q;
    assign result_valid = rv_q;
endmodule

// file: verification/bscrc_assertions.sv
// checker: timing and value relations on the byte bus and unit state
`timescale 1ns/1ps
module bscrc_assertions
    import bscrc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // byte bus
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [BSCRC_AW-1:0] addr,
    input wire logic [BSCRC_DW-1:0] wdata,
    input wire logic [BSCRC_DW-1:0] rdata,
    // unit state
    input wire logic [15:0] running_checksum,
    input wire logic polynomial_select,
    input wire logic update_done
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // one update per input write, done by the next cycle
    a_update_next_cycle: assert property (wr_en && addr == BSCRC_IDX_INPUT |=> update_done)
        else $error("input write gave no update pulse");
    // a lone data bit 0 from a zero sum yields the polynomial itself
    a_polynomial_select_constant: assert property (wr_en && addr == BSCRC_IDX_INPUT && wdata == 8'h01
        && running_checksum == 16'h0000 |=> running_checksum ==
        (polynomial_select ? BSCRC_POLYNOMIAL_SELECT_CRC16 : BSCRC_POLYNOMIAL_SELECT_CCITT))
        else $error("single byte result is not the polynomial");
    a_low_load: assert property (wr_en && addr == BSCRC_IDX_LOW |=>
        running_checksum[7:0] == $past(wdata) && !update_done)
        else $error("low byte write did not load");
    a_high_load: assert property (wr_en && addr == BSCRC_IDX_HIGH |=>
        running_checksum[15:8] == $past(wdata) && !update_done)
        else $error("high byte write did not load");
    a_sum_holds: assert property (!wr_en |=> $stable(running_checksum))
        else $error("checksum moved without a write");
    a_polynomial_select_write: assert property (wr_en && addr == BSCRC_IDX_CTRL |=>
        polynomial_select == $past(wdata[BSCRC_POLYNOMIAL_SELECT_BIT]))
        else $error("control write did not set polynomial");
    a_read_low: assert property (rd_en && addr == BSCRC_IDX_LOW |=>
        rdata == $past(running_checksum[7:0]))
        else $error("low byte read back wrong");
    a_read_high: assert property (rd_en && addr == BSCRC_IDX_HIGH |=>
        rdata == $past(running_checksum[15:8]))
        else $error("high byte read back wrong");
    // no update pulse without an input write
    a_no_stray_update: assert property (!(wr_en && addr == BSCRC_IDX_INPUT) |=>
        !update_done)
        else $error("update pulse without input write");
    // main scenarios seen
    c_input_write: cover property (wr_en && addr == BSCRC_IDX_INPUT);
    c_crc16_pick: cover property (wr_en && addr == BSCRC_IDX_CTRL && wdata[BSCRC_POLYNOMIAL_SELECT_BIT]);
    c_high_read: cover property (rd_en && addr == BSCRC_IDX_HIGH);
endmodule

// file: verification/bscrc_unit_tb.sv
// testbench: host commands drive the crc unit, results checked against known sums
`timescale 1ns/1ps
module bscrc_unit_tb
    import bscrc_pkg::*;
;
    logic clk, rst_b, cmd_valid, cmd_ready, result_valid, polynomial_select_sel, upd;
    bscrc_cmd_t cmd;
    logic [15:0] cmd_data, result, run_sum;
    int bad_count = 0;
    int cmp_count = 0;
    // single byte sums, then running sums over 78 56 34 12
    localparam logic [15:0] ONE[2][8] = '{'{16'h0000, 16'h1021, 16'h2042, 16'h3063,
        16'h4084, 16'h50A5, 16'h60C6, 16'h70E7}, '{16'h0000, 16'h8005, 16'h800F,
        16'h000A, 16'h801B, 16'h001E, 16'h0014, 16'h8011}};
    localparam logic [15:0] SEQ[2][4] = '{'{16'hFF9F, 16'hBBC3, 16'hA367, 16'hD0FA},
        '{16'h0110, 16'h91F1, 16'hF2DE, 16'h5C43}};
    localparam logic [7:0] SIN[4] = '{8'h78, 8'h56, 8'h34, 8'h12};
    bscrc_if bscrc_if_i();
    bscrc_unit bscrc_unit_i (.clk(clk), .rst_b(rst_b), .bus(bscrc_if_i.dev),
        .running_checksum(run_sum), .polynomial_select(polynomial_select_sel), .update_done(upd));
    bscrc_host bscrc_host_i (.clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd(cmd),
        .cmd_data(cmd_data), .cmd_ready(cmd_ready), .result(result),
        .result_valid(result_valid), .bus(bscrc_if_i.host));
    bscrc_assertions bscrc_assertions_i (.clk(clk), .rst_b(rst_b), .wr_en(bscrc_if_i.wr_en),
        .rd_en(bscrc_if_i.rd_en), .addr(bscrc_if_i.addr), .wdata(bscrc_if_i.wdata),
        .rdata(bscrc_if_i.rdata), .running_checksum(run_sum),
        .polynomial_select(polynomial_select_sel), .update_done(upd));
    // 50 ns clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic summarize();
        if (bad_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one command; result awaited under a bound unless it is a polynomial pick
    task automatic go(input bscrc_cmd_t c, input logic [15:0] d, input logic [15:0] exp);
        int n = 0;
        while (cmd_ready !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd <= c;
        cmd_data <= d;
        @(posedge clk);
        cmd_valid <= 1'b0;
        n = 0;
        while (c != BSCRC_CMD_POLYNOMIAL_SELECT && result_valid !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        if (c != BSCRC_CMD_POLYNOMIAL_SELECT) chk(result, exp);
        @(negedge clk);
    endtask
    // main sequence over both polynomials
    initial begin
        cmd_valid = 1'b0;
        cmd = BSCRC_CMD_CLEAR;
        cmd_data = 16'h0000;
        rst_b = 1'b0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        chk(run_sum, 16'h0000);
        chk({15'h0000, polynomial_select_sel}, 16'h0000);
        for (int p = 0; p < 2; p++) begin
            go(BSCRC_CMD_POLYNOMIAL_SELECT, 16'(p), 16'h0000);
            chk({15'h0000, polynomial_select_sel}, 16'(p));
            for (int b = 0; b < 8; b++) begin
                go(BSCRC_CMD_CLEAR, 16'h0000, 16'h0000);
                go(BSCRC_CMD_BYTE, 16'(b), ONE[p][b]);
            end
            go(BSCRC_CMD_CLEAR, 16'h0000, 16'h0000);
            for (int b = 0; b < 4; b++) go(BSCRC_CMD_BYTE, {8'h00, SIN[b]}, SEQ[p][b]);
            go(BSCRC_CMD_CLEAR, 16'h0000, 16'h0000);
            go(BSCRC_CMD_WORD, 16'h5678, SEQ[p][1]);
            go(BSCRC_CMD_WORD, 16'h1234, SEQ[p][3]);
        end
        summarize();
    end
    // watchdog against a hang
    initial begin
        #(50 * 5000);
        bad_count++;
        summarize();
    end
endmodule
